// ==== design/itd_interrogation_decoder.sv ====
// interrogation decoder: mode, address and pulse decode with axi4-lite config
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// [RULE1] mode 1 drives short command output
// [RULE2] mode 2 switch closure, 3 high power
// [RULE3] modes 7,8,A,B drive transfer/acquisition outputs
// [RULE4] mode C single, E double analog
// [RULE5] load address from bits 10..14, 10 msb
// [RULE6] channel address bits 23..30, 23 lsb
// [RULE7] pulses from bits 3..6, pulse4 needs extfmt off
// [RULE8] six-bit terminal address, msb at bit 6
// [RULE9] inhibit blocks switch closure commands
// [RULE10] terminal unavailable means no response at all
// [RULE11] select high central, low remote mode
// [RULE12] master reset low holds all logic reset
// [RULE13] user oscillator times bus, timeout output low
// [RULE14] dual drive enables both buses together
// [RULE15] remote mode emits response data and enable
// [RULE16] test input must be tied to ground
// [RULE17] timeout after sixteen oscillator periods idle
// [RULE18] at most one mode output, none unlisted
module itd_interrogation_decoder (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // interrogation word from the bus receiver, same clock
   input wire logic [31:0] ibus_word,
   input wire logic ibus_valid,
   // pins from outside the clock domain
   input wire logic master_reset_n,
   input wire logic user_timeout_osc,
   input wire logic test_in,
   // mode outputs
   output logic short_cmd_strobe,
   output logic switch_closure_cmd,
   output logic high_power_cmd,
   output logic block_xfer_mode_out,
   output logic bilevel_acq_out,
   output logic serial16_acq_out,
   output logic serial8_acq_out,
   output logic single_ended_analog_out,
   output logic double_ended_analog_out,
   // address and broadcast outputs
   output logic [4:0] mem_load_addr,
   output logic [7:0] channel_addr,
   output logic [3:0] bcast_pulse,
   output logic bcast_pulses_valid,
   // timeout, bus drive and response
   output logic ibus_timeout_n,
   output logic nom_bus_en,
   output logic red_bus_en,
   output logic resp_tx_data,
   output logic resp_tx_enable
);
   import itd_pkg::*;

   logic mrst_s1_r, mrst_s2_r;
   logic osc_s1_r, osc_s2_r, osc_d_r;
   logic test_s1_r, test_s2_r;
   logic rst;
   logic [ITD_CTRL_W-1:0] ctrl_r;
   logic [5:0] term_addr_r;
   logic [15:0] resp_word_r;
   logic [31:0] last_word_r;
   logic [3:0] mode_last_r;
   logic aw_got_r, w_got_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [3:0] mode;
   logic [ITD_NMODES-1:0] mode_hot;
   logic [ITD_NMODES-1:0] mode_out_r;
   logic addr_match;
   logic [4:0] tmo_cnt_r;
   logic tmo_r;
   logic osc_rise;
   logic [15:0] resp_sh_r;
   logic [4:0] resp_cnt_r;
   logic resp_busy;
   logic resp_start;
   logic wr_go;
   logic [31:0] rd_val;
   logic rd_ok;

   // pin synchronisers; only the second stage is read
   always_ff @(posedge aclk) begin
      mrst_s1_r <= master_reset_n;
      mrst_s2_r <= mrst_s1_r;
      osc_s1_r <= user_timeout_osc;
      osc_s2_r <= osc_s1_r;
      test_s1_r <= test_in;
      test_s2_r <= test_s1_r;
   end

   // master reset pin resets everything the bus reset does
   assign rst = !aresetn || !mrst_s2_r; // [RULE12]

   // ---- axi4-lite write side: address and data taken in either order
   assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (rst) begin
         aw_got_r <= 1'b0;
         awaddr_r <= 8'h00;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_got_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         w_got_r <= 1'b0;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_got_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_got_r <= 1'b0;
         end
      end
   end

   // write response; unmapped or read-only offsets answer slverr
   always_ff @(posedge aclk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ITD_AXI_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awaddr_r == ITD_CTRL_OFS || awaddr_r == ITD_TADDR_OFS ||
                         awaddr_r == ITD_RESP_OFS) ? ITD_AXI_OKAY : ITD_AXI_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // configuration registers, byte lanes honoured
   always_ff @(posedge aclk) begin
      if (rst) begin
         ctrl_r <= ITD_CTRL_RST;
         term_addr_r <= ITD_TADDR_RST;
         resp_word_r <= ITD_RESP_RST;
      end else if (wr_go) begin
         if (awaddr_r == ITD_CTRL_OFS && wstrb_r[0]) begin
            ctrl_r <= wdata_r[ITD_CTRL_W-1:0]; // [RULE11]
         end
         if (awaddr_r == ITD_TADDR_OFS && wstrb_r[0]) begin
            term_addr_r <= wdata_r[5:0]; // [RULE8]
         end
         if (awaddr_r == ITD_RESP_OFS) begin
            if (wstrb_r[0]) begin
               resp_word_r[7:0] <= wdata_r[7:0];
            end
            if (wstrb_r[1]) begin
               resp_word_r[15:8] <= wdata_r[15:8];
            end
         end
      end
   end

   // ---- axi4-lite read side
   always_comb begin
      rd_val = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         ITD_CTRL_OFS: rd_val[ITD_CTRL_W-1:0] = ctrl_r;
         ITD_TADDR_OFS: rd_val[5:0] = term_addr_r;
         ITD_RESP_OFS: rd_val[15:0] = resp_word_r;
         ITD_STATUS_OFS: rd_val[7:0] = {mode_last_r, 1'b0, test_s2_r, resp_busy, tmo_r};
         ITD_LAST_OFS: rd_val = last_word_r;
         default: rd_ok = 1'b0;
      endcase
   end

   // one read at a time; arready pulses as the address is taken
   always_ff @(posedge aclk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= ITD_AXI_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? ITD_AXI_OKAY : ITD_AXI_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ---- mode decode; bit 19 taken as the mode msb
   assign mode = {ibus_word[ITD_MODE_LO], ibus_word[ITD_MODE_LO+1],
                  ibus_word[ITD_MODE_LO+2], ibus_word[ITD_MODE_HI]};

   // one comparator per output; distinct codes keep it one-hot
   for (genvar i = 0; i < ITD_NMODES; i++) begin : g_mode
      if (i == ITD_M_SWC) begin : g_swc
         assign mode_hot[i] = (mode == ITD_MODE_CODE[i]) && !ctrl_r[ITD_CTRL_INH]; // [RULE9]
      end else begin : g_plain
         assign mode_hot[i] = (mode == ITD_MODE_CODE[i]); // [RULE18]
      end
   end

   // decoded outputs except bcast_pulses_valid hold until the next interrogation
   always_ff @(posedge aclk) begin
      if (rst) begin
         mode_out_r <= '0;
         mode_last_r <= 4'h0;
         mem_load_addr <= 5'h00;
         channel_addr <= 8'h00;
         bcast_pulse <= 4'h0;
         bcast_pulses_valid <= 1'b0;
         last_word_r <= 32'h00000000;
      end else if (ibus_valid) begin
         mode_out_r <= mode_hot; // [RULE1] [RULE2] [RULE3] [RULE4]
         mode_last_r <= mode;
         last_word_r <= ibus_word;
         mem_load_addr <= {ibus_word[ITD_MLA_LO], ibus_word[ITD_MLA_LO+1],
                           ibus_word[ITD_MLA_LO+2], ibus_word[ITD_MLA_LO+3],
                           ibus_word[ITD_MLA_HI]}; // [RULE5]
         channel_addr <= ibus_word[ITD_CHA_HI:ITD_CHA_LO]; // [RULE6]
         bcast_pulse <= {ibus_word[ITD_BCP_LO+3] && !ctrl_r[ITD_CTRL_EXT],
                         ibus_word[ITD_BCP_LO+2:ITD_BCP_LO]}; // [RULE7]
         bcast_pulses_valid <= 1'b1; // [RULE7]
      end else begin
         bcast_pulses_valid <= 1'b0;
      end
   end

   assign short_cmd_strobe = mode_out_r[0];
   assign switch_closure_cmd = mode_out_r[1];
   assign high_power_cmd = mode_out_r[2];
   assign block_xfer_mode_out = mode_out_r[3];
   assign bilevel_acq_out = mode_out_r[4];
   assign serial16_acq_out = mode_out_r[5];
   assign serial8_acq_out = mode_out_r[6];
   assign single_ended_analog_out = mode_out_r[7];
   assign double_ended_analog_out = mode_out_r[8];

   // ---- interrogation timeout on user oscillator rising edges
   always_ff @(posedge aclk) begin
      if (rst) begin
         osc_d_r <= 1'b0;
      end else begin
         osc_d_r <= osc_s2_r;
      end
   end
   assign osc_rise = osc_s2_r && !osc_d_r;

   // an interrogation restarts the count, so a late word still clears it
   always_ff @(posedge aclk) begin
      if (rst) begin
         tmo_cnt_r <= 5'h00;
         tmo_r <= 1'b0;
      end else if (ibus_valid) begin
         tmo_cnt_r <= 5'h00;
         tmo_r <= 1'b0;
      end else if (osc_rise && !tmo_r) begin
         tmo_cnt_r <= tmo_cnt_r + 5'h01;
         tmo_r <= (tmo_cnt_r + 5'h01) == ITD_TMO_PERIODS; // [RULE17]
      end
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         ibus_timeout_n <= 1'b1;
      end else begin
         ibus_timeout_n <= !tmo_r; // [RULE13]
      end
   end

   // ---- bus drive enables; dual drive overrides the selection
   always_ff @(posedge aclk) begin
      if (rst) begin
         nom_bus_en <= 1'b0;
         red_bus_en <= 1'b0;
      end else begin
         nom_bus_en <= ctrl_r[ITD_CTRL_DUAL] || !ctrl_r[ITD_CTRL_RSEL]; // [RULE14]
         red_bus_en <= ctrl_r[ITD_CTRL_DUAL] || ctrl_r[ITD_CTRL_RSEL]; // [RULE14]
      end
   end

   // ---- response: addressed interrogation in remote mode, terminal available
   assign addr_match = {ibus_word[ITD_TA_LO], ibus_word[ITD_TA_LO+1], ibus_word[ITD_TA_LO+2],
                        ibus_word[ITD_TA_LO+3], ibus_word[ITD_TA_LO+4],
                        ibus_word[ITD_TA_HI]} == term_addr_r; // [RULE8]
   assign resp_busy = resp_cnt_r != 5'h00;
   assign resp_start = ibus_valid && addr_match && !resp_busy &&
                       ctrl_r[ITD_CTRL_TAV] && // [RULE10]
                       !ctrl_r[ITD_CTRL_CNR]; // [RULE11]

   // msb first; dropping availability aborts a response under way
   always_ff @(posedge aclk) begin
      if (rst) begin
         resp_sh_r <= 16'h0000;
         resp_cnt_r <= 5'h00;
         resp_tx_data <= 1'b0;
         resp_tx_enable <= 1'b0;
      end else if (!ctrl_r[ITD_CTRL_TAV]) begin
         resp_cnt_r <= 5'h00; // [RULE10]
         resp_tx_data <= 1'b0;
         resp_tx_enable <= 1'b0;
      end else if (resp_start) begin
         resp_sh_r <= {resp_word_r[14:0], 1'b0};
         resp_cnt_r <= ITD_RESP_BITS - 5'h01;
         resp_tx_data <= resp_word_r[15]; // [RULE15]
         resp_tx_enable <= 1'b1; // [RULE15]
      end else if (resp_busy) begin
         resp_sh_r <= {resp_sh_r[14:0], 1'b0};
         resp_cnt_r <= resp_cnt_r - 5'h01;
         resp_tx_data <= resp_sh_r[15];
         resp_tx_enable <= 1'b1;
      end else begin
         resp_tx_data <= 1'b0;
         resp_tx_enable <= 1'b0;
      end
   end

endmodule

// ==== design/itd_pkg.sv ====
// shared constants for the interrogation decoder
package itd_pkg;
   // register byte offsets
   localparam logic [7:0] ITD_CTRL_OFS = 8'h00;
   localparam logic [7:0] ITD_TADDR_OFS = 8'h04;
   localparam logic [7:0] ITD_RESP_OFS = 8'h08;
   localparam logic [7:0] ITD_STATUS_OFS = 8'h0c;
   localparam logic [7:0] ITD_LAST_OFS = 8'h10;
   // control field positions
   localparam int ITD_CTRL_TAV = 0;
   localparam int ITD_CTRL_CNR = 1;
   localparam int ITD_CTRL_INH = 2;
   localparam int ITD_CTRL_DUAL = 3;
   localparam int ITD_CTRL_RSEL = 4;
   localparam int ITD_CTRL_EXT = 5;
   localparam int ITD_CTRL_W = 6;
   // values after reset
   localparam logic [5:0] ITD_CTRL_RST = 6'h01;
   localparam logic [5:0] ITD_TADDR_RST = 6'h00;
   localparam logic [15:0] ITD_RESP_RST = 16'h0000;
   // interrogation word field positions (index = interrogation bit number)
   localparam int ITD_MODE_LO = 19;
   localparam int ITD_MODE_HI = 22;
   localparam int ITD_MLA_LO = 10;
   localparam int ITD_MLA_HI = 14;
   localparam int ITD_CHA_LO = 23;
   localparam int ITD_CHA_HI = 30;
   localparam int ITD_BCP_LO = 3;
   localparam int ITD_TA_LO = 6;
   localparam int ITD_TA_HI = 11;
   // mode codes, one per mode output, in output order
   localparam int ITD_NMODES = 9;
   localparam logic [3:0] ITD_MODE_CODE [ITD_NMODES] = '{
      4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'ha, 4'hb, 4'hc, 4'he};
   localparam int ITD_M_SWC = 1;
   // timing: user oscillator periods before timeout, response length
   localparam logic [4:0] ITD_TMO_PERIODS = 5'h10;
   localparam logic [4:0] ITD_RESP_BITS = 5'h10;
   // axi response codes
   localparam logic [1:0] ITD_AXI_OKAY = 2'h0;
   localparam logic [1:0] ITD_AXI_SLVERR = 2'h2;
endpackage

// ==== verif/itd_checker.sv ====
// port assertions for the interrogation decoder
`timescale 1ns/1ns
module itd_checker (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // interrogation word
   input wire logic [31:0] ibus_word,
   input wire logic ibus_valid,
   // decoded outputs
   input wire logic short_cmd_strobe,
   input wire logic switch_closure_cmd,
   input wire logic high_power_cmd,
   input wire logic block_xfer_mode_out,
   input wire logic bilevel_acq_out,
   input wire logic serial16_acq_out,
   input wire logic serial8_acq_out,
   input wire logic single_ended_analog_out,
   input wire logic double_ended_analog_out,
   input wire logic [4:0] mem_load_addr,
   input wire logic [7:0] channel_addr,
   input wire logic [3:0] bcast_pulse,
   input wire logic bcast_pulses_valid,
   input wire logic resp_tx_enable
);
   logic [31:0] word_r;
   logic [3:0] mode;
   logic [8:0] outs;
   // last taken word, fields are compared one cycle later
   always_ff @(posedge aclk) begin
      if (ibus_valid) word_r <= ibus_word;
   end
   // mode field carries its msb in bit 19
   assign mode = {ibus_word[19], ibus_word[20], ibus_word[21], ibus_word[22]};
   // all nine mode outputs, so a stray pair anywhere is caught
   assign outs = {short_cmd_strobe, switch_closure_cmd, high_power_cmd, block_xfer_mode_out,
      bilevel_acq_out, serial16_acq_out, serial8_acq_out, single_ended_analog_out,
      double_ended_analog_out};
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_decoded;
      ##1 bcast_pulses_valid;
   endsequence
   short_cmd_a: assert property (ibus_valid && mode == 4'h1 |=> short_cmd_strobe)
      else $error("short command missing");
   high_power_a: assert property (ibus_valid && mode == 4'h3 |=> high_power_cmd)
      else $error("high power command missing");
   switch_closure_a: assert property (ibus_valid && mode != 4'h2 |=>
      !switch_closure_cmd)
      else $error("switch closure on wrong mode");
   serial_acq_a: assert property (ibus_valid && mode == 4'hb |=>
      serial8_acq_out && !serial16_acq_out)
      else $error("serial acquisition decode wrong");
   double_analog_a: assert property (ibus_valid && mode == 4'he |=>
      double_ended_analog_out)
      else $error("double analog decode wrong");
   load_addr_a: assert property (ibus_valid |=> mem_load_addr ==
      {word_r[10], word_r[11], word_r[12], word_r[13], word_r[14]})
      else $error("load address wrong");
   chan_addr_a: assert property (ibus_valid |=> channel_addr == word_r[30:23])
      else $error("channel address wrong");
   pulse_field_a: assert property (ibus_valid |->
      s_decoded ##0 bcast_pulse[2:0] == word_r[5:3])
      else $error("broadcast pulses wrong");
   pulse_valid_a: assert property (bcast_pulses_valid |-> $past(ibus_valid))
      else $error("pulse valid without word");
   one_mode_a: assert property ($onehot0(outs))
      else $error("several mode outputs high");
   resp_start_a: assert property ($rose(resp_tx_enable) |-> $past(ibus_valid))
      else $error("response without interrogation");
endmodule
bind itd_interrogation_decoder itd_checker u_chk (.*);

// ==== verif/itd_user_model.sv ====
// user-side oscillator and test pin model
`timescale 1ns/1ns
module itd_user_model (
   // control from the bench
   input wire logic run,
   // pins toward the decoder
   output logic user_timeout_osc,
   output logic test_in,
   // rising edges made so far
   output int n_edges
);
   int edge_cnt = 0;
   assign test_in = 1'b0;
   // slow oscillator, parked low so no stray edge reaches the count;
   // toggles on 120 ns steps so it never lands on a rising clock edge
   initial begin
      user_timeout_osc = 1'b0;
      forever begin
         #120;
         if (run) user_timeout_osc = ~user_timeout_osc;
         else user_timeout_osc = 1'b0;
      end
   end
   always @(posedge user_timeout_osc) edge_cnt++;
   assign n_edges = edge_cnt;
endmodule

// ==== verif/test_interrogation_decoder.sv ====
// self-checking bench for the interrogation decoder
`timescale 1ns/1ns
module test_interrogation_decoder;
   import itd_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, master_reset_n = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ibus_valid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, ibus_word = 32'h0, s_axi_rdata, seed = 32'h28, w, d;
   logic [3:0] s_axi_wstrb = 4'hf, bcast_pulse;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic user_timeout_osc, test_in, ibus_timeout_n, nom_bus_en, red_bus_en;
   logic resp_tx_data, resp_tx_enable, bcast_pulses_valid, short_cmd_strobe;
   logic switch_closure_cmd, high_power_cmd, block_xfer_mode_out, bilevel_acq_out;
   logic serial16_acq_out, serial8_acq_out, single_ended_analog_out, double_ended_analog_out;
   logic [4:0] mem_load_addr;
   logic [7:0] channel_addr;
   logic [8:0] outs;
   logic [15:0] rw;
   logic [5:0] ta;
   int n_edges, e0, n_mismatch = 0, check_count = 0;
   // mode outputs gathered in code-table order
   assign outs = {double_ended_analog_out, single_ended_analog_out, serial8_acq_out,
      serial16_acq_out, bilevel_acq_out, block_xfer_mode_out, high_power_cmd,
      switch_closure_cmd, short_cmd_strobe};
   itd_interrogation_decoder dut (.*);
   itd_user_model partner (.*);
   always #25 aclk = ~aclk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // mode code goes in msb first from bit 19
   function automatic logic [31:0] put_mode(input logic [31:0] x, input logic [3:0] c);
      x[22:19] = {c[0], c[1], c[2], c[3]};
      return x;
   endfunction
   // terminal address msb sits at bit 6
   function automatic logic [31:0] put_ta(input logic [31:0] x, input logic [5:0] t);
      for (int i = 0; i < 6; i++) x[6 + i] = t[5 - i];
      return x;
   endfunction
   function automatic logic [8:0] exp_modes(input logic [3:0] c, input logic inh);
      logic [8:0] v;
      for (int i = 0; i < ITD_NMODES; i++) v[i] = (ITD_MODE_CODE[i] == c);
      if (inh) v[ITD_M_SWC] = 1'b0;
      return v;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic send(input logic [31:0] x);
      @(posedge aclk);
      ibus_word <= x;
      ibus_valid <= 1'b1;
      @(posedge aclk);
      ibus_valid <= 1'b0;
      #1;
   endtask
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] e);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      e = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      e = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // about 4000 cycles, several times the expected run
   initial begin
      #200000;
      n_mismatch++;
      wrap_up;
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ITD_CTRL_OFS, d, r);
      chk(d, 32'(ITD_CTRL_RST));
      rd(8'h40, d, r);
      chk(r, ITD_AXI_SLVERR);
      chk(d, 32'h0);
      wr(ITD_STATUS_OFS, 32'h0, r);
      chk(r, ITD_AXI_SLVERR);
      chk({nom_bus_en, red_bus_en}, 2'b10);
      // every mode code with random surrounding bits
      for (int c = 0; c < 16; c++) begin
         seed = lfsr(seed);
         w = put_mode(seed, 4'(c));
         send(w);
         chk(outs, exp_modes(4'(c), 1'b0));
         chk(mem_load_addr, {w[10], w[11], w[12], w[13], w[14]});
         chk(channel_addr, w[30:23]);
         chk({bcast_pulses_valid, bcast_pulse}, {1'b1, w[6:3]});
      end
      $display("mode decode done");
      wr(ITD_CTRL_OFS, 32'h25, r);
      send(put_mode(32'h40, 4'h2));
      chk(outs, exp_modes(4'h2, 1'b1));
      chk(bcast_pulse[3], 1'b0);
      wr(ITD_CTRL_OFS, 32'h09, r);
      repeat (2) @(posedge aclk);
      #1;
      chk({nom_bus_en, red_bus_en}, 2'b11);
      $display("controls done");
      seed = lfsr(seed);
      ta = seed[5:0];
      rw = seed[31:16];
      wr(ITD_TADDR_OFS, 32'(ta), r);
      wr(ITD_RESP_OFS, 32'(rw), r);
      wr(ITD_CTRL_OFS, 32'h01, r);
      send(put_ta(put_mode(seed, 4'h1), ta));
      for (int i = 15; i >= 0; i--) begin
         chk({resp_tx_enable, resp_tx_data}, {1'b1, rw[i]});
         @(posedge aclk);
         #1;
      end
      chk(resp_tx_enable, 1'b0);
      // unavailable, central mode, then address msb wrong
      for (int k = 0; k < 3; k++) begin
         wr(ITD_CTRL_OFS, k == 0 ? 32'h00 : k == 1 ? 32'h03 : 32'h01, r);
         send(put_ta(put_mode(seed, 4'h1), k == 2 ? ta ^ 6'h20 : ta));
         chk({short_cmd_strobe, resp_tx_enable}, 2'b10);
      end
      $display("response done");
      send(32'h0);
      e0 = n_edges;
      run <= 1'b1;
      wait (n_edges == e0 + 15);
      @(posedge aclk);
      run <= 1'b0;
      repeat (10) @(posedge aclk);
      #1;
      chk(ibus_timeout_n, 1'b1);
      @(posedge aclk);
      run <= 1'b1;
      wait (n_edges == e0 + 16);
      @(posedge aclk);
      run <= 1'b0;
      repeat (8) @(posedge aclk);
      #1;
      chk(ibus_timeout_n, 1'b0);
      send(32'h0);
      repeat (2) @(posedge aclk);
      #1;
      chk(ibus_timeout_n, 1'b1);
      $display("timeout done");
      send(put_mode(32'hffffffff, 4'h7));
      @(posedge aclk);
      master_reset_n <= 1'b0;
      repeat (4) @(posedge aclk);
      #1;
      chk({outs, channel_addr, ibus_timeout_n}, {17'h0, 1'b1});
      @(posedge aclk);
      master_reset_n <= 1'b1;
      repeat (4) @(posedge aclk);
      $display("master reset done");
      wrap_up;
   end
endmodule
